//--- rtl/pwm_edge_mux_fault_logic.v
// Output shaping and fault response for four PWM channels, AHB-Lite slave.
// Assumes raw A/B, blanking and period pulses come from the same-clock
// waveform logic; fault sources and peak-current trips arrive asynchronously.
//
// What this block does
// [RULE1] Aux pulse C rises at blanking begin and falls at blanking end.
// [RULE2] Edge builder uses own and next channel A and B outputs.
// [RULE3] Channel 3 treats channel 0 as its next channel.
// [RULE4] Three-bit codes pick each edge: own A/B rise/fall, then next channel's.
// [RULE5] Output A mux: own A, gen A, own C, own B, next A/B, C of n+1..n+3.
// [RULE6] Output B mux: own B, gen B, own C, own A, next A/B, C of n+1..n+3.
// [RULE7] Mux selections follow the automatic operating mode config set.
// [RULE8] Mux enabled forces high resolution off; edges land on clock grid.
// [RULE9] Mux disabled passes raw A and B straight through.
// [RULE10] Mux channel indices wrap modulo four.
// [RULE11] Four identical fault modules per channel: per-cycle, both, A, B.
// [RULE12] Each fault module counts at most one fault per switching period.
// [RULE13] Flag sets only when consecutive faulted periods exceed max count.
// [RULE14] Flags stay set until channel enable drops, clearing all together.
// [RULE15] One common fault enable gates all four modules of a channel.
// [RULE16] One per-cycle block per channel reacts to peak current trips.
// [RULE17] Any source combination may feed any fault input of any channel.
// [RULE18] Sources: comparators, pins, limits, overvoltage, diode emulation, clock, DCM.
// [RULE19] Generated output sets on rise event and clears on fall event.
// [RULE20] A set flag forces its outputs low.
//
// Our own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "pwm_edge_mux_defines.vh"

module pwm_edge_mux_fault_logic (
   input wire i_clk,
   input wire i_rst_b,
   input wire i_hsel,
   input wire [31:0] i_haddr,
   input wire [1:0] i_htrans,
   input wire i_hwrite,
   input wire [2:0] i_hsize,
   input wire [31:0] i_hwdata,
   input wire i_hready,
   output reg [31:0] o_hrdata,
   output wire o_hreadyout,
   output wire o_hresp,
   input wire [3:0] i_pwm_a,
   input wire [3:0] i_pwm_b,
   input wire [3:0] i_blank_begin,
   input wire [3:0] i_blank_end,
   input wire [3:0] i_period_start,
   input wire [7:0] i_auto_mode,
   input wire [23:0] i_fault_src,
   input wire [3:0] i_pcm_trip,
   output wire [3:0] o_pwm_a,
   output wire [3:0] o_pwm_b,
   output wire [3:0] o_hires_en
);

   ////////////////////////////////////////////////////////////////////////////
   // Synchronisers for asynchronous fault sources and peak-current trips
   //
   // Only the second stage is read by logic, so a first stage that goes
   // metastable never fans out into the fault counters.
   // Costs two cycles of fault latency; comparators are far slower anyway.
   //

   reg [27:0] sync1_q;
   reg [27:0] sync2_q;
   wire [23:0] src_s;
   wire [3:0] pcm_s;

   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sync1_q <= 28'h0000000;
         sync2_q <= 28'h0000000;
      end else begin
         sync1_q <= {i_pcm_trip, i_fault_src};
         sync2_q <= sync1_q;
      end
   end

   assign src_s = sync2_q[23:0];
   assign pcm_s = sync2_q[27:24];

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave: zero wait states, always OKAY
   //
   // Sixteen word slots per channel, four channels, one status word.
   // Slots past the mux config words are unmapped: writes are dropped
   // and reads return zero, so firmware can probe safely.
   // Transfer size is not checked; every access is a whole word.
   //

   reg [31:0] cfg_q [0:63];
   reg wr_pend_q;
   reg [5:0] wr_idx_q;
   wire take;
   wire [5:0] a_idx;
   wire cfg_hit;
   wire stat_hit;
   wire [15:0] flag;
   wire [3:0] aux_c;
   reg [31:0] rd_val;
   integer k;

   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;
   assign take = i_hsel & i_htrans[1] & i_hready;
   assign a_idx = {i_haddr[7:6], i_haddr[5:2]};
   assign cfg_hit = (i_haddr[31:8] == 24'h000000) && (i_haddr[5:2] <= `R_LAST);
   assign stat_hit = (i_haddr[31:2] == {21'h000000, `A_STATUS >> 2});

   always @* begin
      rd_val = 32'h00000000;
      if (stat_hit)
         rd_val = {12'h000, aux_c, flag};
      else if (cfg_hit)
         rd_val = cfg_q[a_idx];
   end

   // Read data is latched in the address phase; a read directly behind a
   // write to the same word would see the old value, so masters idle between.
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wr_pend_q <= 1'b0;
         wr_idx_q <= 6'h00;
         o_hrdata <= 32'h00000000;
      end else if (take) begin
         wr_pend_q <= i_hwrite & cfg_hit;
         wr_idx_q <= a_idx;
         if (!i_hwrite)
            o_hrdata <= rd_val;
      end else begin
         wr_pend_q <= 1'b0;
      end
   end

   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         for (k = 0; k < 64; k = k + 1)
            cfg_q[k] <= `RST_WORD;
      end else if (wr_pend_q) begin
         cfg_q[wr_idx_q] <= i_hwdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Edge detection on raw channel outputs
   //
   // Raw waveforms are on this clock, so no synchroniser is needed.
   // Previous values reset low to match the idle level of the waveforms,
   // so no false rising edge follows reset.
   //

   reg [3:0] pa_q;
   reg [3:0] pb_q;
   wire [3:0] rise_a;
   wire [3:0] fall_a;
   wire [3:0] rise_b;
   wire [3:0] fall_b;

   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pa_q <= 4'h0;
         pb_q <= 4'h0;
      end else begin
         pa_q <= i_pwm_a;
         pb_q <= i_pwm_b;
      end
   end

   assign rise_a = i_pwm_a & ~pa_q;
   assign fall_a = ~i_pwm_a & pa_q;
   assign rise_b = i_pwm_b & ~pb_q;
   assign fall_b = ~i_pwm_b & pb_q;

   // Out-of-range selections fall back to the pass-through input
   function pick;
      input [3:0] sel;
      input [8:0] opts;
      begin
         if (sel <= 4'h8)
            pick = opts[sel];
         else
            pick = opts[0];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Fault modules, four per channel
   //
   // Entry f serves channel f/4, module f%4. A hit within a period is
   // held until the period start, so several pulses count only once.
   // The counter saturates instead of wrapping, so a long fault burst
   // can never fold back below the maximum and hide itself.
   // A fault in the period start cycle counts for the period now ending.
   //

   wire [15:0] fin;
   wire [3:0] en_v;
   wire [3:0] fen_v;

   genvar f;
   generate
      for (f = 0; f < 16; f = f + 1) begin : g_fault
         localparam CH = f / 4;
         localparam M = f % 4;
         wire [31:0] mask = cfg_q[CH * 16 + `R_MASK0 + M];
         wire [7:0] maxc = cfg_q[CH * 16 + `R_MAXCNT][M * 8 + 7:M * 8];
         wire now;
         reg hit_q;
         reg [7:0] cnt_q;
         reg flag_q;

         // [RULE17] Source mux
         // [RULE18] Any source set
         // [RULE16] Trip feeds per-cycle module
         assign fin[f] = (|(mask[23:0] & src_s)) | ((M == `M_CBC) ? pcm_s[CH] : 1'b0);
         // [RULE15] Common fault enable
         assign now = fin[f] & fen_v[CH];
         assign flag[f] = flag_q;

         // [RULE11] Identical module body
         always @(posedge i_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
               hit_q <= 1'b0;
               cnt_q <= 8'h00;
               flag_q <= 1'b0;
            // [RULE14] Enable low clears
            end else if (!en_v[CH]) begin
               hit_q <= 1'b0;
               cnt_q <= 8'h00;
               flag_q <= 1'b0;
            end else if (i_period_start[CH]) begin
               // [RULE12] One per period
               hit_q <= 1'b0;
               if (hit_q | now) begin
                  if (cnt_q != 8'hff)
                     cnt_q <= cnt_q + 8'h01;
                  // [RULE13] Count exceeds max
                  if (cnt_q >= maxc)
                     flag_q <= 1'b1;
               end else begin
                  cnt_q <= 8'h00;
               end
            end else if (now) begin
               hit_q <= 1'b1;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Per-channel aux pulse, edge builder, output mux and output stage
   //
   // Generated outputs and the aux pulse are registered, so they reach
   // the pins one cycle later than the raw waveforms do.
   // With the mux on, edges land on the clock grid only; fine placement
   // is switched off at the same time to keep both sides consistent.
   // Auto mode codes two and three both take the high set.
   //

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_ch
         // [RULE3] Next channel wraps
         // [RULE10] Indices modulo four
         localparam N1 = (g + 1) % 4;
         localparam N2 = (g + 2) % 4;
         localparam N3 = (g + 3) % 4;
         wire [31:0] ctrl = cfg_q[g * 16 + `R_CTRL];
         wire [1:0] am = i_auto_mode[2 * g + 1:2 * g];
         wire [31:0] mcfg;
         wire [7:0] ev;
         wire mux_en;
         wire sel_a;
         wire sel_b;
         wire kill_a;
         wire kill_b;
         reg c_q;
         reg gen_a_q;
         reg gen_b_q;
         reg cut_q;
         reg out_a_q;
         reg out_b_q;
         reg hires_q;

         assign en_v[g] = ctrl[`F_EN];
         assign fen_v[g] = ctrl[`F_FAULT_EN];
         assign aux_c[g] = c_q;

         // [RULE7] Set follows auto mode
         assign mcfg = (am == 2'b00) ? cfg_q[g * 16 + `R_MUX_LO] :
                       (am == 2'b01) ? cfg_q[g * 16 + `R_MUX_MID] :
                       cfg_q[g * 16 + `R_MUX_HI];
         assign mux_en = mcfg[`F_MUX_EN];

         // [RULE2] Own and next edges
         // [RULE4] Edge code order
         assign ev = {fall_b[N1], rise_b[N1], fall_a[N1], rise_a[N1],
                      fall_b[g], rise_b[g], fall_a[g], rise_a[g]};

         always @(posedge i_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
               c_q <= 1'b0;
               gen_a_q <= 1'b0;
               gen_b_q <= 1'b0;
               cut_q <= 1'b0;
            end else if (!en_v[g]) begin
               c_q <= 1'b0;
               gen_a_q <= 1'b0;
               gen_b_q <= 1'b0;
               cut_q <= 1'b0;
            end else begin
               // [RULE1] Blanking window pulse
               if (i_blank_begin[g])
                  c_q <= 1'b1;
               else if (i_blank_end[g])
                  c_q <= 1'b0;
               // [RULE19] Set on rise, clear on fall
               if (ev[ctrl[`F_EDGE_A_RISE]])
                  gen_a_q <= 1'b1;
               else if (ev[ctrl[`F_EDGE_A_FALL]])
                  gen_a_q <= 1'b0;
               if (ev[ctrl[`F_EDGE_B_RISE]])
                  gen_b_q <= 1'b1;
               else if (ev[ctrl[`F_EDGE_B_FALL]])
                  gen_b_q <= 1'b0;
               // [RULE16] Trip ends A for the cycle
               if (fen_v[g] & fin[g * 4 + `M_CBC])
                  cut_q <= 1'b1;
               else if (i_period_start[g])
                  cut_q <= 1'b0;
            end
         end

         // [RULE5] Output A choices
         // [RULE9] Pass-through when off
         assign sel_a = mux_en ? pick(mcfg[`F_SEL_A],
                        {aux_c[N3], aux_c[N2], aux_c[N1], i_pwm_b[N1], i_pwm_a[N1],
                         i_pwm_b[g], c_q, gen_a_q, i_pwm_a[g]}) : i_pwm_a[g];
         // [RULE6] Output B choices
         assign sel_b = mux_en ? pick(mcfg[`F_SEL_B],
                        {aux_c[N3], aux_c[N2], aux_c[N1], i_pwm_b[N1], i_pwm_a[N1],
                         i_pwm_a[g], c_q, gen_b_q, i_pwm_b[g]}) : i_pwm_b[g];

         // [RULE20] Flags force low
         assign kill_a = flag[g * 4 + `M_CBC] | flag[g * 4 + `M_AB] |
                         flag[g * 4 + `M_A] | cut_q;
         assign kill_b = flag[g * 4 + `M_CBC] | flag[g * 4 + `M_AB] |
                         flag[g * 4 + `M_B];

         always @(posedge i_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
               out_a_q <= 1'b0;
               out_b_q <= 1'b0;
               hires_q <= 1'b0;
            end else begin
               out_a_q <= en_v[g] & ~kill_a & sel_a;
               out_b_q <= en_v[g] & ~kill_b & sel_b;
               // [RULE8] Mux forces coarse edges
               hires_q <= ctrl[`F_HIRES] & ~mux_en;
            end
         end

         assign o_pwm_a[g] = out_a_q;
         assign o_pwm_b[g] = out_b_q;
         assign o_hires_en[g] = hires_q;
      end
   endgenerate

endmodule // pwm_edge_mux_fault_logic

//--- rtl/pwm_edge_mux_defines.vh
// Constants for the PWM edge builder, output select mux and fault logic.
// Assumes a 32-bit AHB-Lite slave map with one word per register.
`ifndef PWM_EDGE_MUX_DEFINES_VH
`define PWM_EDGE_MUX_DEFINES_VH

// Register word index inside a channel block (channel stride 0x40)
`define R_CTRL 4'h0
`define R_MAXCNT 4'h1
`define R_MASK0 4'h2
`define R_MUX_LO 4'h6
`define R_MUX_MID 4'h7
`define R_MUX_HI 4'h8
`define R_LAST 4'h8
// Status register byte address
`define A_STATUS 9'h100

// Control register fields
`define F_EN 0
`define F_FAULT_EN 1
`define F_HIRES 2
`define F_EDGE_A_RISE 6:4
`define F_EDGE_A_FALL 10:8
`define F_EDGE_B_RISE 14:12
`define F_EDGE_B_FALL 18:16
// Mux config fields
`define F_MUX_EN 0
`define F_SEL_A 7:4
`define F_SEL_B 11:8

// Reset values
`define RST_WORD 32'h0000_0000

// Fault module order inside a channel
`define M_CBC 0
`define M_AB 1
`define M_A 2
`define M_B 3

// Fault source vector width
`define NSRC 24

// Output edge granularity with high resolution on (mux off), and clock period
`define EDGE_STEP_PS 4000
`define CLK_PERIOD_PS 25000

`endif

//--- verif/pwr_stage_model.sv
// Far side model: protection comparators raising fault sources and trips.
// Assumes the bench asks for levels; outputs move away from the clock edge.
`timescale 1ns/1ps
module pwr_stage_model (
   input wire i_clk,
   input wire [23:0] i_fault_req,
   input wire [3:0] i_trip_req,
   output logic [23:0] o_fault_src,
   output logic [3:0] o_pcm_trip
);
   initial begin
      o_fault_src = 24'h0;
      o_pcm_trip = 4'h0;
   end
   // full source vector
   // Comparators are not clock aligned, so change mid cycle
   always @(posedge i_clk) begin
      #9;
      o_fault_src <= i_fault_req;
      o_pcm_trip <= i_trip_req;
   end
endmodule // pwr_stage_model

//--- verif/pwm_edge_mux_props.sv
// Checker: bus answer, reset idle and output relations at the block ports.
// Assumes one AHB master; control writes are shadowed from the bus.
`timescale 1ns/1ps
module pwm_edge_mux_props (
   input wire i_clk,
   input wire i_rst_b,
   input wire i_hsel,
   input wire [31:0] i_haddr,
   input wire [1:0] i_htrans,
   input wire i_hwrite,
   input wire [31:0] i_hwdata,
   input wire i_hready,
   input wire [31:0] o_hrdata,
   input wire o_hreadyout,
   input wire o_hresp,
   input wire [3:0] i_pwm_a,
   input wire [3:0] i_pwm_b,
   input wire [7:0] i_auto_mode,
   input wire [3:0] o_pwm_a,
   input wire [3:0] o_pwm_b,
   input wire [3:0] o_hires_en
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   ////////////////////////////////////////////////////////////
   // Output relations are only judged once the config has been quiet
   reg [31:0] wa_q;
   reg wp_q;
   reg [1:0] qt_q;
   reg [3:0] en_q, fen_q, hi_q, cm;
   reg [3:0] mx_q [0:2];
   reg [7:0] am_q;
   wire tk = i_hsel && i_htrans[1] && i_hready;
   wire [5:0] off = wa_q[5:0];
   integer n;
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wa_q <= 32'h0;
         wp_q <= 1'b0;
         qt_q <= 2'd0;
         en_q <= 4'h0;
         fen_q <= 4'h0;
         hi_q <= 4'h0;
         mx_q[0] <= 4'h0;
         mx_q[1] <= 4'h0;
         mx_q[2] <= 4'h0;
         am_q <= 8'h0;
      end else begin
         am_q <= i_auto_mode;
         if (tk)
            wa_q <= i_haddr;
         if (i_hready)
            wp_q <= tk && i_hwrite;
         if (qt_q != 2'd3)
            qt_q <= qt_q + 2'd1;
         if (wp_q && i_hready && wa_q[31:8] == 24'h0) begin
            qt_q <= 2'd0;
            if (off == 6'h00) begin
               en_q[wa_q[7:6]] <= i_hwdata[0];
               fen_q[wa_q[7:6]] <= i_hwdata[1];
               hi_q[wa_q[7:6]] <= i_hwdata[2];
            end
            if (off >= 6'h18 && off <= 6'h20)
               mx_q[off[4:2] - 3'd6][wa_q[7:6]] <= i_hwdata[0];
         end
      end
   end
   // Mux enable of the set picked by last cycle's mode
   always @* begin
      for (n = 0; n < 4; n = n + 1)
         cm[n] = mx_q[am_q[2*n+1] ? 2'd2 : {1'b0, am_q[2*n]}][n];
   end
   sequence rd_gap;
      tk && !i_hwrite && i_haddr[31:8] == 24'h0 && i_haddr[5:0] >= 6'h24;
   endsequence
   bus_ready_a: assert property (o_hreadyout == 1'b1)
      else $error("wait state inserted");
   resp_okay_a: assert property (o_hresp == 1'b0)
      else $error("error response");
   reset_idle_a: assert property ($rose(i_rst_b) |-> (o_pwm_a | o_pwm_b | o_hires_en) == 4'h0)
      else $error("outputs busy after reset");
   gap_zero_a: assert property (rd_gap |=> o_hrdata == 32'h0)
      else $error("unmapped read gave data");
   rdata_hold_a: assert property (!(tk && !i_hwrite) |=> $stable(o_hrdata))
      else $error("read data moved");
   off_low_a: assert property (qt_q == 2'd3 |-> ((o_pwm_a | o_pwm_b) & ~en_q) == 4'h0)
      else $error("disabled channel drives");
   pass_thru_a: assert property (qt_q == 2'd3 |->
      (((o_pwm_a ^ $past(i_pwm_a)) | (o_pwm_b ^ $past(i_pwm_b))) & en_q & ~fen_q & ~cm) == 4'h0)
      else $error("raw waveform altered");
   hires_gate_a: assert property (qt_q == 2'd3 |-> o_hires_en == (hi_q & ~cm))
      else $error("fine edge enable wrong");
endmodule // pwm_edge_mux_props
bind pwm_edge_mux_fault_logic pwm_edge_mux_props props (.*);

//--- verif/tb.sv
// Bench for the PWM edge mux and fault block: bus, mux, edge builder, faults.
// Assumes the block is the lone AHB slave; a stage model feeds fault inputs.
`timescale 1ns/1ps
module tb;
   logic i_clk, i_rst_b, i_hsel, i_hwrite, look, osel;
   logic [31:0] i_haddr, i_hwdata;
   logic [1:0] i_htrans;
   logic [3:0] i_pwm_a, i_pwm_b, i_blank_begin, i_blank_end, i_period_start;
   logic [3:0] a, b, cb, ea, eb, tripq;
   logic [7:0] i_auto_mode;
   logic [23:0] freq;
   wire [31:0] o_hrdata;
   wire o_hreadyout, o_hresp;
   wire [3:0] o_pwm_a, o_pwm_b, o_hires_en, i_pcm_trip;
   wire [23:0] i_fault_src;
   wire i_hready = o_hreadyout;
   wire [2:0] i_hsize = 3'h2;
   logic [31:0] q[$];
   int error_cnt, total_checks, n, s, k, m, c;
   pwm_edge_mux_fault_logic dut (.*);
   pwr_stage_model stage (.i_clk(i_clk), .i_fault_req(freq), .i_trip_req(tripq),
      .o_fault_src(i_fault_src), .o_pcm_trip(i_pcm_trip));
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   initial begin
      repeat (40000) @(posedge i_clk);
      error_cnt++;
      end_of_test();
   end
   ////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge i_clk)
      if (look) check(osel ? {20'h0, o_hires_en, o_pwm_b, o_pwm_a} : o_hrdata, q.pop_front());
   task automatic wait_rdy();
      repeat (20) begin
         @(posedge i_clk);
         if (o_hreadyout === 1'b1)
            return;
      end
      error_cnt++;
      end_of_test();
   endtask
   // Idle cycle after each transfer keeps reads off pending writes
   task automatic xfer(input logic w, input logic [31:0] ad, input logic [31:0] d);
      i_htrans <= 2'h2;
      i_haddr <= ad;
      i_hwrite <= w;
      wait_rdy();
      i_htrans <= 2'h0;
      i_hwdata <= d;
      look <= !w;
      osel <= 1'b0;
      wait_rdy();
      look <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic rd(input logic [31:0] ad, input logic [31:0] ex);
      q.push_back(ex);
      xfer(1'b0, ad, 32'h0);
   endtask
   task automatic look_out(input logic [31:0] ex);
      q.push_back(ex);
      osel <= 1'b1;
      look <= 1'b1;
      @(posedge i_clk);
      look <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic drive(input logic [3:0] na, input logic [3:0] nb);
      i_pwm_a <= na;
      i_pwm_b <= nb;
      repeat (4) @(posedge i_clk);
   endtask
   function automatic logic pick(int sel, logic own, logic oth);
      logic [8:0] t;
      t = {cb[2:0], b[0], a[0], oth, cb[3], 1'b0, own};
      return t[sel];
   endfunction
   ////////////////////////////////////////////////////////////
   initial begin
      {i_rst_b, i_hwrite, look, osel, i_htrans, freq} = '0;
      {i_haddr, i_hwdata, i_pwm_a, i_pwm_b, i_auto_mode} = '0;
      {i_blank_begin, i_blank_end, i_period_start, tripq} = '0;
      i_hsel = 1'b1;
      s = $urandom(58);
      repeat (6) @(posedge i_clk);
      i_rst_b <= 1'b1;
      @(posedge i_clk);
      rd(32'h0, 32'h0);
      rd(32'hc4, 32'h0);
      c = $urandom & 32'h0007_7770;
      xfer(1'b1, 32'h40, c);
      rd(32'h40, c);
      xfer(1'b1, 32'h64, 32'hffff_ffff);
      rd(32'h64, 32'h0);
      for (n = 0; n < 4; n++)
         xfer(1'b1, n * 64, n == 0 ? 32'h5 : 32'h1);
      repeat (6) begin
         a = 4'($urandom);
         b = 4'($urandom);
         drive(a, b);
         look_out({20'h0, 4'h1, b, a});
      end
      xfer(1'b1, 32'hc0, 32'h5);
      cb = 4'($urandom);
      i_blank_begin <= cb;
      @(posedge i_clk);
      i_blank_begin <= 4'h0;
      repeat (3) @(posedge i_clk);
      rd(32'h100, {12'h0, cb, 16'h0});
      m = $urandom_range(2);
      i_auto_mode <= {m == 2 ? 2'($urandom_range(3, 2)) : 2'(m), 6'($urandom)};
      for (s = 0; s < 18; s++) begin
         k = s % 9;
         if (k != 1) begin
            xfer(1'b1, 32'hd8 + 4 * m, s < 9 ? k * 16 + 1 : k * 256 + 1);
            a = 4'($urandom);
            b = 4'($urandom);
            drive(a, b);
            ea = a;
            eb = b;
            if (s < 9)
               ea[3] = pick(k, a[3], b[3]);
            else
               eb[3] = pick(k, b[3], a[3]);
            look_out({20'h0, 4'h1, eb, ea});
         end
      end
      i_blank_end <= 4'hf;
      @(posedge i_clk);
      i_blank_end <= 4'h0;
      xfer(1'b1, 32'hd8 + 4 * m, 32'h111);
      for (c = 0; c < 8; c++) begin
         xfer(1'b1, 32'hc0, 1 | c << 4 | (c ^ 1) << 8 | c << 12 | (c ^ 1) << 16);
         a = 4'($urandom);
         b = 4'($urandom);
         for (n = 0; n < 3; n++) begin
            if (c[1])
               b[c[2] ? 0 : 3] = n[0];
            else
               a[c[2] ? 0 : 3] = n[0];
            drive(a, b);
            ea = {n[0] ^ c[0], a[2:0]};
            eb = {n[0] ^ c[0], b[2:0]};
            if (n > 0)
               look_out({20'h0, 4'h1, eb, ea});
         end
      end
      xfer(1'b1, 32'hd8 + 4 * m, 32'h0);
      m = $urandom_range(3, 1);
      s = $urandom_range(22);
      xfer(1'b1, 32'h84, m << 16);
      xfer(1'b1, 32'h90, 1 << s);
      xfer(1'b1, 32'h80, 32'h3);
      drive(4'hf, 4'hf);
      for (n = 1; n <= m + 1; n++) begin
         repeat (2) begin
            freq <= 24'h1 << s;
            @(posedge i_clk);
            freq <= 24'h0;
            @(posedge i_clk);
         end
         repeat (4) @(posedge i_clk);
         i_period_start <= 4'h4;
         @(posedge i_clk);
         i_period_start <= 4'h0;
         repeat (3) @(posedge i_clk);
         look_out({20'h0, 4'h1, 4'hf, n > m ? 4'hb : 4'hf});
      end
      rd(32'h100, 32'h400);
      xfer(1'b1, 32'h80, 32'h0);
      rd(32'h100, 32'h0);
      xfer(1'b1, 32'h80, 32'h3);
      repeat (3) @(posedge i_clk);
      look_out({20'h0, 4'h1, 4'hf, 4'hf});
      // Peak current trip on channel 2, fault enable off then on
      for (n = 0; n < 2; n++) begin
         xfer(1'b1, 32'h80, n == 0 ? 32'h1 : 32'h3);
         repeat (3) @(posedge i_clk);
         tripq <= 4'h4;
         @(posedge i_clk);
         tripq <= 4'h0;
         repeat (4) @(posedge i_clk);
         look_out({20'h0, 4'h1, 4'hf, n == 0 ? 4'hf : 4'hb});
      end
      end_of_test();
   end
endmodule // tb
